// File: logic/gyr_spi_regs.v
// spi slave register bank of the rate gyroscope
// Functional notes
// - each write frame changes one byte; a full word needs two frames
// - frame 0xBE01 starts bias null right after its sixteenth rising edge
// - a read is a command frame, then data returned in the next frame
// - seven-bit read address; odd or even byte returns the same word
// - command in a data frame selects the word sent in the next frame
// - each register has even lower byte address, upper byte one above
// - output words carry a new-data flag while holding an unread value
// - output words carry an error flag when any diagnostic flag is set
// - rate output is read-only fourteen-bit two's complement
// - rate weight per count follows the selected measurement range
// - temperature output is read-only twelve-bit, zero near 25 degrees
// - supply output is read-only twelve-bit unsigned
// - analog input output is read-only twelve-bit unsigned
// - read-only flash write counter survives resets, cleared only at power-on
// - read-only part identifier returns a fixed code, ignores writes
// - mode 3 link, msb first, sixteen-bit frames
// - after reset, nonvolatile copies load into working registers first
// - frame 0xBE08 stores flash-backed controls into nonvolatile memory
`timescale 1ns/1ns
`include "gyr_map.vh"
module gyr_spi_regs #(
   parameter [15:0] PART_ID = 16'h1234, // arbitrary value
   parameter [15:0] LOT_CODE1 = 16'h0001, // arbitrary value
   parameter [15:0] LOT_CODE2 = 16'h0002, // arbitrary value
   parameter [15:0] SERIAL_NO = 16'h0003 // arbitrary value
) (
   // clock, resets, enable
   input wire ref_clk,
   input wire arst_n,
   input wire pwr_on_n,
   input wire clk_en,
   // spi pins
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_din,
   output wire spi_dout,
   output wire spi_dout_oe,
   // samples from the sensing core
   input wire sample_load,
   input wire [11:0] supply_value,
   input wire [13:0] rate_value,
   input wire [11:0] aux_value,
   input wire [11:0] temp_value,
   input wire [13:0] angle_value,
   input wire [15:0] diag_value,
   // controls to the sensing core
   output wire producing,
   output reg bias_null_start,
   output reg flash_store_start,
   output wire [2:0] range_select,
   output wire [15:0] rate_offset_trim,
   output wire [15:0] rate_scale_trim,
   output wire [15:0] alarm_control,
   output wire [15:0] misc_control,
   output wire [15:0] sample_period,
   output wire [15:0] range_and_filter,
   output wire [15:0] sleep_duration,
   output reg [15:0] dac_output_level,
   output reg [15:0] digital_io_control
);
   // ==================================================
   // helpers
   function [3:0] ctl_index;
      input [6:0] addr;
      begin
         case ({addr[6:1], 1'b0})
            `GYR_ADDR_OFFSET: ctl_index = `GYR_IDX_OFFSET;
            `GYR_ADDR_SCALE: ctl_index = `GYR_IDX_SCALE;
            `GYR_ADDR_ALM1_THR: ctl_index = `GYR_IDX_ALM1_THR;
            `GYR_ADDR_ALM2_THR: ctl_index = `GYR_IDX_ALM2_THR;
            `GYR_ADDR_ALM1_WIN: ctl_index = `GYR_IDX_ALM1_WIN;
            `GYR_ADDR_ALM2_WIN: ctl_index = `GYR_IDX_ALM2_WIN;
            `GYR_ADDR_ALARM_CTRL: ctl_index = `GYR_IDX_ALARM_CTRL;
            `GYR_ADDR_MISC: ctl_index = `GYR_IDX_MISC;
            `GYR_ADDR_PERIOD: ctl_index = `GYR_IDX_PERIOD;
            `GYR_ADDR_RANGE: ctl_index = `GYR_IDX_RANGE;
            `GYR_ADDR_SLEEP: ctl_index = `GYR_IDX_SLEEP;
            default: ctl_index = `GYR_IDX_NONE;
         endcase
      end
   endfunction

   function [15:0] ctl_default;
      input [3:0] idx;
      begin
         case (idx)
            `GYR_IDX_SCALE: ctl_default = `GYR_RST_SCALE;
            `GYR_IDX_PERIOD: ctl_default = `GYR_RST_PERIOD;
            `GYR_IDX_RANGE: ctl_default = `GYR_RST_RANGE;
            default: ctl_default = `GYR_RST_ZERO;
         endcase
      end
   endfunction

   // lower byte at even address, upper byte at odd
   function [15:0] merge_byte;
      input [15:0] old;
      input upper;
      input [7:0] data;
      begin
         if (upper)
            merge_byte = {data, old[7:0]};
         else
            merge_byte = {old[15:8], data};
      end
   endfunction

   // ==================================================
   // storage
   reg [15:0] ctl [0:`GYR_NV_WORDS-1];
   reg [15:0] nvm [0:`GYR_NV_WORDS-1];
   reg [15:0] flash_write_count;
   reg [1:0] state;
   reg [3:0] load_idx;
   reg [11:0] supply_sample;
   reg [13:0] rate_sample;
   reg [11:0] aux_sample;
   reg [11:0] temp_sample;
   reg [13:0] angle_accumulator;
   reg [15:0] diagnostic_flags;
   reg [4:0] new_data_flag;
   reg [6:0] read_addr;
   reg [15:0] tx_word;
   wire [2:0] pins_s;
   wire frame_start;
   wire frame_done;
   wire [15:0] rx_word;
   wire error_alarm_flag;
   wire is_write;
   wire [6:0] wr_addr;
   wire [7:0] wr_data;
   wire [3:0] wr_idx;
   wire [3:0] rd_idx;
   wire wr_ok;
   integer i;
   integer j;

   // ==================================================
   // pins and shifter
   gyr_sync #(
      .W(3),
      .IDLE(3'h7)
   ) u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .pin_in({spi_sclk, spi_cs_n, spi_din}),
      .pin_sync(pins_s)
   );

   gyr_spi_shift u_shift (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .sclk_s(pins_s[2]),
      .cs_n_s(pins_s[1]),
      .din_s(pins_s[0]),
      .tx_word(tx_word),
      .frame_start(frame_start),
      .frame_done(frame_done),
      .rx_word(rx_word),
      .spi_dout(spi_dout),
      .spi_dout_oe(spi_dout_oe)
   );

   // ==================================================
   // command decode
   assign is_write = rx_word[`GYR_BIT_WRITE];
   assign wr_addr = rx_word[14:8];
   assign wr_data = rx_word[7:0];
   assign wr_idx = ctl_index(wr_addr);
   assign rd_idx = ctl_index(read_addr);
   // write frames are ignored until the load after reset has finished
   assign wr_ok = frame_done & is_write & (state == `GYR_ST_RUN);
   assign producing = (state != `GYR_ST_LOAD);

   // any diagnostic flag raises the error bit of every output word
   assign error_alarm_flag = |diagnostic_flags;

   // ==================================================
   // control outputs
   assign rate_offset_trim = ctl[`GYR_IDX_OFFSET];
   assign rate_scale_trim = ctl[`GYR_IDX_SCALE];
   assign alarm_control = ctl[`GYR_IDX_ALARM_CTRL];
   assign misc_control = ctl[`GYR_IDX_MISC];
   assign sample_period = ctl[`GYR_IDX_PERIOD];
   assign range_and_filter = ctl[`GYR_IDX_RANGE];
   assign sleep_duration = ctl[`GYR_IDX_SLEEP];
   // the core rescales rate counts from this setting
   assign range_select = range_and_filter[`GYR_RANGE_MSB:`GYR_RANGE_LSB];

   // ==================================================
   // read data for the next frame
   always @* begin
      // odd and even byte address pick the same word
      case ({read_addr[6:1], 1'b0})
         `GYR_ADDR_WR_COUNT: tx_word = flash_write_count;
         `GYR_ADDR_SUPPLY:
            tx_word = {new_data_flag[0], error_alarm_flag, 2'h0,
                       supply_sample};
         `GYR_ADDR_RATE:
            tx_word = {new_data_flag[1], error_alarm_flag,
                       rate_sample};
         `GYR_ADDR_AUX:
            tx_word = {new_data_flag[2], error_alarm_flag, 2'h0,
                       aux_sample};
         `GYR_ADDR_TEMP:
            tx_word = {new_data_flag[3], error_alarm_flag, 2'h0,
                       temp_sample};
         `GYR_ADDR_ANGLE:
            tx_word = {new_data_flag[4], error_alarm_flag,
                       angle_accumulator};
         `GYR_ADDR_DAC: tx_word = dac_output_level;
         `GYR_ADDR_GPIO: tx_word = digital_io_control;
         `GYR_ADDR_DIAG: tx_word = diagnostic_flags;
         `GYR_ADDR_LOT1: tx_word = LOT_CODE1;
         `GYR_ADDR_LOT2: tx_word = LOT_CODE2;
         `GYR_ADDR_PART_ID: tx_word = PART_ID;
         `GYR_ADDR_SERIAL: tx_word = SERIAL_NO;
         default: begin
            // reserved and write-only locations read as zero
            if (rd_idx != `GYR_IDX_NONE)
               tx_word = ctl[rd_idx];
            else
               tx_word = 16'h0000;
         end
      endcase
   end

   // every read frame's command picks the next frame's word
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         read_addr <= 7'h00;
      end else if (clk_en) begin
         if (frame_done && !is_write)
            read_addr <= wr_addr;
      end
   end

   // ==================================================
   // nonvolatile copy; only a power-on resets it to its default words
   always @(posedge ref_clk or negedge pwr_on_n) begin
      if (!pwr_on_n) begin
         for (j = 0; j < `GYR_NV_WORDS; j = j + 1)
            nvm[j] <= ctl_default(j[3:0]);
         flash_write_count <= 16'h0000;
      end else if (clk_en && state == `GYR_ST_STORE) begin
         for (j = 0; j < `GYR_NV_WORDS; j = j + 1)
            nvm[j] <= ctl[j];
         flash_write_count <= flash_write_count + 16'h0001;
      end
   end

   // ==================================================
   // control state: load after reset, run, store
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= `GYR_ST_LOAD;
         load_idx <= 4'h0;
         for (i = 0; i < `GYR_NV_WORDS; i = i + 1)
            ctl[i] <= ctl_default(i[3:0]);
         dac_output_level <= 16'h0000;
         digital_io_control <= 16'h0000;
         bias_null_start <= 1'b0;
         flash_store_start <= 1'b0;
      end else if (clk_en) begin
         bias_null_start <= 1'b0;
         flash_store_start <= 1'b0;
         case (state)
            `GYR_ST_LOAD: begin
               // one word a cycle, then data production starts
               ctl[load_idx] <= nvm[load_idx];
               load_idx <= load_idx + 4'h1;
               if (load_idx == `GYR_IDX_LAST)
                  state <= `GYR_ST_RUN;
            end
            `GYR_ST_RUN: begin
               if (wr_ok) begin
                  if (wr_idx != `GYR_IDX_NONE)
                     ctl[wr_idx] <= merge_byte(ctl[wr_idx],
                                               wr_addr[0], wr_data);
                  case ({wr_addr[6:1], 1'b0})
                     `GYR_ADDR_DAC:
                        dac_output_level <= merge_byte(dac_output_level,
                                                       wr_addr[0], wr_data);
                     `GYR_ADDR_GPIO:
                        digital_io_control <= merge_byte(digital_io_control,
                                                         wr_addr[0], wr_data);
                     `GYR_ADDR_COMMAND: begin
                        if (!wr_addr[0]) begin
                           // one-cycle strobe three cycles after the sixteenth rise is sampled
                           bias_null_start <= wr_data[`GYR_CMD_BIAS_BIT];
                           flash_store_start <= wr_data[`GYR_CMD_STORE_BIT];
                           if (wr_data[`GYR_CMD_STORE_BIT])
                              state <= `GYR_ST_STORE;
                        end
                     end
                     default: begin
                        // read-only words ignore writes
                     end
                  endcase
               end
            end
            `GYR_ST_STORE: begin
               state <= `GYR_ST_RUN;
            end
            default: begin
               state <= `GYR_ST_LOAD;
               load_idx <= 4'h0;
            end
         endcase
      end
   end

   // ==================================================
   // sample registers and new-data flags
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         supply_sample <= 12'h000;
         rate_sample <= 14'h0000;
         aux_sample <= 12'h000;
         temp_sample <= 12'h000;
         angle_accumulator <= 14'h0000;
         diagnostic_flags <= 16'h0000;
         new_data_flag <= 5'h00;
      end else if (clk_en) begin
         diagnostic_flags <= diag_value;
         // a word that starts shifting out is no longer unread
         if (frame_start) begin
            case ({read_addr[6:1], 1'b0})
               `GYR_ADDR_SUPPLY: new_data_flag[0] <= 1'b0;
               `GYR_ADDR_RATE: new_data_flag[1] <= 1'b0;
               `GYR_ADDR_AUX: new_data_flag[2] <= 1'b0;
               `GYR_ADDR_TEMP: new_data_flag[3] <= 1'b0;
               `GYR_ADDR_ANGLE: new_data_flag[4] <= 1'b0;
               default: begin
               end
            endcase
         end
         if (wr_ok && {wr_addr[6:1], 1'b0} == `GYR_ADDR_ANGLE) begin
            if (wr_addr[0])
               angle_accumulator[13:8] <= wr_data[5:0];
            else
               angle_accumulator[7:0] <= wr_data;
         end
         // placed last so a new sample beats a same-cycle clear
         if (sample_load && producing) begin
            supply_sample <= supply_value;
            rate_sample <= rate_value;
            aux_sample <= aux_value;
            temp_sample <= temp_value;
            angle_accumulator <= angle_value;
            new_data_flag <= 5'h1F;
         end
      end
   end
endmodule // gyr_spi_regs

// File: logic/gyr_map.vh
// register map, field positions, reset values and counts of the gyro spi block
`ifndef GYR_MAP_VH
`define GYR_MAP_VH
// ==================================================
// byte addresses of the lower byte of each register
`define GYR_ADDR_WR_COUNT 7'h00
`define GYR_ADDR_SUPPLY 7'h02
`define GYR_ADDR_RATE 7'h04
`define GYR_ADDR_AUX 7'h0A
`define GYR_ADDR_TEMP 7'h0C
`define GYR_ADDR_ANGLE 7'h0E
`define GYR_ADDR_OFFSET 7'h14
`define GYR_ADDR_SCALE 7'h16
`define GYR_ADDR_ALM1_THR 7'h20
`define GYR_ADDR_ALM2_THR 7'h22
`define GYR_ADDR_ALM1_WIN 7'h24
`define GYR_ADDR_ALM2_WIN 7'h26
`define GYR_ADDR_ALARM_CTRL 7'h28
`define GYR_ADDR_DAC 7'h30
`define GYR_ADDR_GPIO 7'h32
`define GYR_ADDR_MISC 7'h34
`define GYR_ADDR_PERIOD 7'h36
`define GYR_ADDR_RANGE 7'h38
`define GYR_ADDR_SLEEP 7'h3A
`define GYR_ADDR_DIAG 7'h3C
`define GYR_ADDR_COMMAND 7'h3E
`define GYR_ADDR_LOT1 7'h52
`define GYR_ADDR_LOT2 7'h54
`define GYR_ADDR_PART_ID 7'h56
`define GYR_ADDR_SERIAL 7'h58
// ==================================================
// flash-backed control words: index into working and nonvolatile arrays
`define GYR_NV_WORDS 11
`define GYR_IDX_OFFSET 4'h0
`define GYR_IDX_SCALE 4'h1
`define GYR_IDX_ALM1_THR 4'h2
`define GYR_IDX_ALM2_THR 4'h3
`define GYR_IDX_ALM1_WIN 4'h4
`define GYR_IDX_ALM2_WIN 4'h5
`define GYR_IDX_ALARM_CTRL 4'h6
`define GYR_IDX_MISC 4'h7
`define GYR_IDX_PERIOD 4'h8
`define GYR_IDX_RANGE 4'h9
`define GYR_IDX_SLEEP 4'hA
`define GYR_IDX_NONE 4'hF
`define GYR_IDX_LAST 4'hA
// ==================================================
// reset values
`define GYR_RST_SCALE 16'h0800
`define GYR_RST_PERIOD 16'h0001
`define GYR_RST_RANGE 16'h0402
`define GYR_RST_ZERO 16'h0000
// ==================================================
// frame fields
`define GYR_FRAME_LAST 4'hF
`define GYR_BIT_WRITE 15
`define GYR_NEW_BIT 15
`define GYR_ERR_BIT 14
`define GYR_CMD_BIAS_BIT 0
`define GYR_CMD_STORE_BIT 3
`define GYR_RANGE_MSB 10
`define GYR_RANGE_LSB 8
// ==================================================
// control states
`define GYR_ST_LOAD 2'h0
`define GYR_ST_RUN 2'h1
`define GYR_ST_STORE 2'h2
`endif

// File: logic/gyr_sync.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module gyr_sync #(
   parameter W = 3,
   parameter [W-1:0] IDLE = {W{1'b1}}
) (
   // clock and reset
   input wire ref_clk,
   input wire arst_n,
   input wire clk_en,
   // pins in, synchronised out
   input wire [W-1:0] pin_in,
   output wire [W-1:0] pin_sync
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : bit_sync
         reg stage1;
         reg stage2;
         always @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               stage1 <= IDLE[g];
               stage2 <= IDLE[g];
            end else if (clk_en) begin
               stage1 <= pin_in[g];
               stage2 <= stage1;
            end
         end
         assign pin_sync[g] = stage2;
      end
   endgenerate
endmodule // gyr_sync

// File: logic/gyr_spi_shift.v
// mode 3 spi frame shifter working from sampled serial clock edges
`timescale 1ns/1ns
`include "gyr_map.vh"
module gyr_spi_shift (
   // clock and reset
   input wire ref_clk,
   input wire arst_n,
   input wire clk_en,
   // synchronised pins
   input wire sclk_s,
   input wire cs_n_s,
   input wire din_s,
   // word exchange with the register bank
   input wire [15:0] tx_word,
   output wire frame_start,
   output reg frame_done,
   output reg [15:0] rx_word,
   // serial out
   output reg spi_dout,
   output wire spi_dout_oe
);
   reg sclk_prev;
   reg cs_prev;
   reg [14:0] rx_shift;
   reg [15:0] tx_shift;
   reg [3:0] bit_cnt;
   wire sclk_rise;
   wire sclk_fall;

   assign sclk_rise = sclk_s & ~sclk_prev & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_prev & ~cs_n_s;
   assign frame_start = cs_prev & ~cs_n_s;
   assign spi_dout_oe = ~cs_n_s;

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_prev <= 1'b1;
         cs_prev <= 1'b1;
         rx_shift <= 15'h0000;
         tx_shift <= 16'h0000;
         bit_cnt <= 4'h0;
         frame_done <= 1'b0;
         rx_word <= 16'h0000;
         spi_dout <= 1'b0;
      end else if (clk_en) begin
         sclk_prev <= sclk_s;
         cs_prev <= cs_n_s;
         frame_done <= 1'b0;
         if (frame_start) begin
            bit_cnt <= 4'h0;
            tx_shift <= tx_word;
         end else begin
            // input taken on rising edges, msb first
            if (sclk_rise) begin
               rx_shift <= {rx_shift[13:0], din_s};
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == `GYR_FRAME_LAST) begin
                  rx_word <= {rx_shift, din_s};
                  frame_done <= 1'b1;
               end
            end
            // output moves on falling edges
            if (sclk_fall) begin
               spi_dout <= tx_shift[15];
               tx_shift <= {tx_shift[14:0], 1'b0};
            end
         end
      end
   end
endmodule // gyr_spi_shift

// File: verif/gyr_spi_props.sv
// concurrent checks on the pins of the gyro spi register bank
`timescale 1ns/1ns
module gyr_spi_props (
   // clock and reset
   input logic ref_clk,
   input logic arst_n,
   // spi pins
   input logic spi_sclk,
   input logic spi_cs_n,
   input logic spi_dout,
   input logic spi_dout_oe,
   // core side
   input logic producing,
   input logic bias_null_start,
   input logic flash_store_start,
   input logic [2:0] range_select,
   input logic [15:0] range_and_filter
);
   // ==================================================
   // properties
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_release;
      $rose(arst_n);
   endsequence
   // nonvolatile words must load before data starts
   sequence s_loading;
      !producing [*8];
   endsequence
   a_oe_idle_off: assert property (spi_cs_n [*4] |-> !spi_dout_oe)
      else $error("dout driven while deselected");
   a_oe_sel_on: assert property (!spi_cs_n [*4] |-> spi_dout_oe)
      else $error("dout not driven while selected");
   a_dout_hold: assert property ((!spi_cs_n && spi_sclk) [*6]
      |-> $stable(spi_dout)) else $error("dout moved while sclk high");
   a_bias_single: assert property (bias_null_start |=> !bias_null_start)
      else $error("bias start longer than one cycle");
   a_bias_after_rise: assert property (bias_null_start
      |-> spi_sclk && $past(spi_sclk, 3)) else $error("bias start misplaced");
   a_store_single: assert property (flash_store_start
      |=> !flash_store_start) else $error("store start too long");
   a_boot_wait: assert property (s_release |-> s_loading)
      else $error("producing before load");
   a_boot_done: assert property (s_release |-> ##[9:20] producing)
      else $error("load never finished");
   a_boot_hold: assert property (producing |=> producing)
      else $error("producing dropped");
   a_range_follow: assert property ($stable(range_and_filter) [*2]
      |-> range_select == range_and_filter[10:8]) else $error("range lost");
endmodule // gyr_spi_props
bind gyr_spi_regs gyr_spi_props chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_dout(spi_dout),
   .spi_dout_oe(spi_dout_oe), .producing(producing),
   .bias_null_start(bias_null_start), .flash_store_start(flash_store_start),
   .range_select(range_select), .range_and_filter(range_and_filter));

// File: verif/gyr_master.sv
// spi master model issuing 16-bit mode 3 frames
`timescale 1ns/1ns
module gyr_master (
   // clock
   input logic ref_clk,
   // spi pins
   input logic spi_dout,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_din
);
   // half period in ref_clk cycles; 4 gives the 160 ns serial clock
   int half = 4;
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_din = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // msb first, din moves on the fall and is taken on the rise
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      spi_cs_n <= 1'b0;
      wait_clk(8);
      for (int i = 15; i >= 0; i--) begin
         spi_sclk <= 1'b0;
         spi_din <= tx[i];
         wait_clk(half);
         spi_sclk <= 1'b1;
         wait_clk(half);
         rx[i] = spi_dout;
      end
      spi_cs_n <= 1'b1;
      // released line shows the inverse so no stale bit is trusted
      spi_din <= ~spi_din;
      // stall so the next frame is seen as a new one
      wait_clk(12);
   endtask
endmodule // gyr_master

// File: verif/gyr_spi_regs_tb.sv
// self-checking bench of the gyro spi register bank
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
   err_count++; $display("FAIL %0t got %h want %h", $time, a, b); end end
module gyr_spi_regs_tb;
   localparam logic [15:0] PART = 16'h5A3C; // arbitrary value
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic pwr_on_n = 1'b0;
   logic sample_load = 1'b0;
   logic [11:0] supply_value = 12'h000;
   logic [13:0] rate_value = 14'h0000;
   logic [11:0] aux_value = 12'h000;
   logic [11:0] temp_value = 12'h000;
   logic [13:0] angle_value = 14'h0000;
   logic [15:0] diag_value = 16'h0000;
   logic clk_en = 1'b1;
   wire miso;
   wire [15:0] ofs_w, scl_w, alm_w, msc_w, prd_w, rng_w, slp_w, dac_w, gio_w;
   wire spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe, producing;
   wire bias_null_start, flash_store_start;
   wire [2:0] range_select;
   int err_count = 0;
   int check_count = 0;
   int bias_cnt = 0;
   int store_cnt = 0;
   logic [15:0] rx;
   always #10 ref_clk = ~ref_clk;
   gyr_spi_regs #(.PART_ID(PART)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
      .pwr_on_n(pwr_on_n), .clk_en(clk_en), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout),
      .spi_dout_oe(spi_dout_oe), .sample_load(sample_load),
      .supply_value(supply_value), .rate_value(rate_value),
      .aux_value(aux_value), .temp_value(temp_value),
      .angle_value(angle_value), .diag_value(diag_value),
      .producing(producing), .bias_null_start(bias_null_start),
      .flash_store_start(flash_store_start), .range_select(range_select),
      .rate_offset_trim(ofs_w), .rate_scale_trim(scl_w),
      .alarm_control(alm_w), .misc_control(msc_w), .sample_period(prd_w),
      .range_and_filter(rng_w), .sleep_duration(slp_w),
      .dac_output_level(dac_w), .digital_io_control(gio_w));
   // a deselected output shows inverted so a late enable is caught
   assign miso = spi_dout_oe ? spi_dout : ~spi_dout;
   gyr_master m (.ref_clk(ref_clk), .spi_dout(miso),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_din(spi_din));
   always @(posedge ref_clk) begin
      if (bias_null_start === 1'b1)
         bias_cnt++;
      if (flash_store_start === 1'b1)
         store_cnt++;
   end
   // ==================================================
   // shared tasks
   task automatic end_sim;
      if (err_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // pwr high also resets the nonvolatile copy to its defaults, as a power cycle would
   task automatic do_reset(input logic pwr);
      int n;
      n = 0;
      arst_n <= 1'b0;
      pwr_on_n <= ~pwr;
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      pwr_on_n <= 1'b1;
      while (producing !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      `CHK(producing, 1'b1)
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      m.xfer({1'b1, a, d}, rx);
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      m.xfer({1'b0, a, 8'h00}, rx);
      m.xfer(16'h0000, rx);
      `CHK(rx, exp)
   endtask
   task automatic load(input logic [15:0] diag);
      supply_value <= 12'hAAA;
      rate_value <= 14'h3FFF;
      aux_value <= 12'h7AE;
      temp_value <= 12'hFFF;
      angle_value <= 14'h2663;
      diag_value <= diag;
      sample_load <= 1'b1;
      @(posedge ref_clk);
      sample_load <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   // ==================================================
   // scenarios
   task automatic t_defaults;
      rd(7'h16, 16'h0800);
      rd(7'h17, 16'h0800);
      rd(7'h36, 16'h0001);
      rd(7'h00, 16'h0000);
      `CHK(scl_w, 16'h0800)
      `CHK(prd_w, 16'h0001)
      `CHK(rng_w, 16'h0402)
      `CHK(alm_w | msc_w | slp_w | ofs_w, 16'h0000)
   endtask
   task automatic t_pipeline;
      m.xfer(16'h1600, rx);
      m.xfer(16'h3800, rx);
      `CHK(rx, 16'h0800)
      m.xfer(16'h5700, rx);
      `CHK(rx, 16'h0402)
      m.xfer(16'h0000, rx);
      `CHK(rx, PART)
   endtask
   task automatic t_readonly;
      m.half = 7;
      wr(7'h56, 8'h55);
      rd(7'h56, PART);
      m.half = 4;
      rd(7'h06, 16'h0000);
      rd(7'h3E, 16'h0000);
   endtask
   task automatic t_bytes;
      wr(7'h14, 8'hAB);
      rd(7'h14, 16'h00AB);
      wr(7'h15, 8'hCD);
      rd(7'h15, 16'hCDAB);
      `CHK(ofs_w, 16'hCDAB)
      wr(7'h31, 8'h0F);
      wr(7'h32, 8'h3C);
      rd(7'h30, 16'h0F00);
      rd(7'h33, 16'h003C);
      `CHK(dac_w, 16'h0F00)
      `CHK(gio_w, 16'h003C)
   endtask
   task automatic t_samples;
      load(16'h0000);
      rd(7'h04, 16'hBFFF);
      rd(7'h05, 16'h3FFF);
      load(16'h0004);
      rd(7'h02, 16'hCAAA);
      rd(7'h0C, 16'hCFFF);
      rd(7'h0A, 16'hC7AE);
      rd(7'h0F, 16'hE663);
      wr(7'h0E, 8'h12);
      rd(7'h0E, 16'h6612);
      // frozen enable: the load strobe must leave the flags alone
      clk_en <= 1'b0;
      load(16'h0000);
      clk_en <= 1'b1;
      rd(7'h02, 16'h0AAA);
   endtask
   task automatic t_commands;
      wr(7'h39, 8'h02);
      `CHK(range_select, 3'b010)
      `CHK(rng_w, 16'h0202)
      wr(7'h3E, 8'h01);
      `CHK(bias_cnt, 1)
      wr(7'h3E, 8'h08);
      `CHK(store_cnt, 1)
      rd(7'h00, 16'h0001);
      do_reset(1'b0);
      rd(7'h14, 16'hCDAB);
      rd(7'h38, 16'h0202);
      rd(7'h01, 16'h0001);
   endtask
   initial begin
      do_reset(1'b1);
      t_defaults();
      t_pipeline();
      t_readonly();
      t_bytes();
      t_samples();
      t_commands();
      end_sim();
   end
   initial begin
      #600000;
      err_count++;
      end_sim();
   end
endmodule // gyr_spi_regs_tb
